/* File: src/ccb_core.sv */
// Purpose: Execution unit for clear, watchdog clear, invert, compare-skip and decimal adjust
// Assumes: Instructions pushed by software over classic Wishbone, one per write
// Notes:   A small data memory stands in for the file registers
`timescale 1ns/1ps

module ccb_core
#(
  parameter int MEM_WORDS = 4096,
  parameter int WDT_W     = 16
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Status outputs
  output logic             busy_o,
  output logic             skip_o
);

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    CCB_ST_IDLE = 3'b001,
    CCB_ST_EXEC = 3'b010,
    CCB_ST_NOP  = 3'b100
  } ccb_state_t;

  ccb_state_t  state_q;
  ccb_state_t  state_d;
  logic [15:0] instr_q;
  logic [1:0]  ctrl_q;
  logic [7:0]  acc_q;
  logic [7:0]  flags_q;
  logic [3:0]  bsr_q;
  logic [11:0] fsr_q;
  logic [11:0] raddr_q;
  logic [WDT_W-1:0] wdt_q;
  logic [1:0]  nop_cnt_q;
  logic        skip_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  mem_q [MEM_WORDS];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic ccb_pkg::ccb_dec_t ccb_decode(input logic [15:0] w);
    ccb_pkg::ccb_dec_t r;
    r      = '0;
    r.fadr = w[7:0];
    r.acc  = w[8];
    r.dst  = w[9];
    r.clr  = (w[15:9] == ccb_pkg::CCB_OPC_CLR);
    r.inv  = (w[15:10] == ccb_pkg::CCB_OPC_INV);
    r.wdc  = (w == ccb_pkg::CCB_OPC_WDC);
    r.daj  = (w == ccb_pkg::CCB_OPC_DAJ);
    if (w[15:9] == ccb_pkg::CCB_OPC_SEQ)
      r.cmp = ccb_pkg::CCB_CMP_EQ;
    else if (w[15:9] == ccb_pkg::CCB_OPC_SGT)
      r.cmp = ccb_pkg::CCB_CMP_GT;
    else if (w[15:9] == ccb_pkg::CCB_OPC_SLT)
      r.cmp = ccb_pkg::CCB_CMP_LT;
    return r;
  endfunction

  wire ccb_pkg::ccb_dec_t dec = ccb_decode(instr_q);

  // ----------------------------------------
  // Operand addressing
  // ----------------------------------------
  // Indexed offset only for low access-bank addresses with extended set on
  wire logic        use_idx   = !dec.acc && ctrl_q[ccb_pkg::CCB_CTRL_EXT_BIT]
                                && (dec.fadr <= ccb_pkg::CCB_ACC_LIMIT);
  // Access bank: low half maps to bank 0, upper half to bank 15
  wire logic [11:0] acc_addr  = {{4{dec.fadr[7]}}, dec.fadr};
  wire logic [11:0] bank_addr = {bsr_q, dec.fadr};
  wire logic [11:0] idx_addr  = fsr_q + {4'h0, dec.fadr};
  wire logic [11:0] eff_addr  = use_idx ? idx_addr : (dec.acc ? bank_addr : acc_addr);
  wire logic [7:0]  fval      = mem_q[eff_addr];

  // ----------------------------------------
  // Result path
  // ----------------------------------------
  logic [7:0] res;
  logic       cmp_hit;
  logic       c_new;

  ccb_alu u_alu
  (
    .dec_i  (dec),
    .fval_i (fval),
    .acc_i  (acc_q),
    .c_i    (flags_q[ccb_pkg::CCB_FLG_C_BIT]),
    .dc_i   (flags_q[ccb_pkg::CCB_FLG_DC_BIT]),
    .res_o  (res),
    .skip_o (cmp_hit),
    .c_o    (c_new)
  );

  // Write routing: clear always to file, invert by destination bit
  wire logic exec     = (state_q == CCB_ST_EXEC);
  wire logic to_file  = dec.clr || (dec.inv && dec.dst);
  wire logic to_acc   = (dec.inv && !dec.dst) || dec.daj;
  wire ccb_pkg::ccb_mem_t mw = '{we: exec && to_file, addr: eff_addr, data: res};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic bus_req = cyc_i && stb_i && !ack_q;
  wire logic bus_wr  = bus_req && we_i && sel_i[0];
  wire logic wr_inst = bus_wr && (adr_i == ccb_pkg::CCB_OFS_INSTR) && (state_q == CCB_ST_IDLE);

  // Next state: skip holds the no-op state for one or two cycles before idle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CCB_ST_IDLE: state_d = wr_inst ? CCB_ST_EXEC : CCB_ST_IDLE;
      CCB_ST_EXEC: state_d = cmp_hit ? CCB_ST_NOP : CCB_ST_IDLE;
      CCB_ST_NOP:  state_d = (nop_cnt_q == 2'd1) ? CCB_ST_IDLE : CCB_ST_NOP;
      default:     state_d = CCB_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Sequencing and architectural state
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q   <= CCB_ST_IDLE;
      nop_cnt_q <= 2'd0;
      skip_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (exec && cmp_hit)
      begin
        // Two-word follower costs a second discarded slot
        nop_cnt_q <= ctrl_q[ccb_pkg::CCB_CTRL_TWOW_BIT] ? 2'd2 : 2'd1;
        skip_q    <= 1'b1;
      end
      else if (state_q == CCB_ST_NOP)
      begin
        nop_cnt_q <= nop_cnt_q - 2'd1;
        skip_q    <= (nop_cnt_q != 2'd1);
      end
    end
  end

  // Accumulator, flags, watchdog and software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      instr_q <= 16'h0000;
      ctrl_q  <= 2'h0;
      acc_q   <= ccb_pkg::CCB_RST_BYTE;
      flags_q <= ccb_pkg::CCB_RST_FLAGS;
      bsr_q   <= 4'h0;
      fsr_q   <= 12'h000;
      raddr_q <= 12'h000;
      wdt_q   <= '0;
    end
    else
    begin
      wdt_q <= wdt_q + 1'b1;
      if (wr_inst)
        instr_q <= dat_i[15:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_CTRL)
        ctrl_q <= dat_i[1:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_BSR)
        bsr_q <= dat_i[3:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_FSR)
        fsr_q <= dat_i[11:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_RADDR)
        raddr_q <= dat_i[11:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_ACC)
        acc_q <= dat_i[7:0];
      if (bus_wr && adr_i == ccb_pkg::CCB_OFS_FLAGS)
        flags_q <= dat_i[7:0];
      if (exec)
      begin
        if (to_acc)
          acc_q <= res;
        if (dec.clr)
          flags_q[ccb_pkg::CCB_FLG_Z_BIT] <= 1'b1;
        if (dec.inv)
        begin
          flags_q[ccb_pkg::CCB_FLG_Z_BIT] <= (res == 8'h00);
          flags_q[ccb_pkg::CCB_FLG_N_BIT] <= res[7];
        end
        if (dec.daj)
          flags_q[ccb_pkg::CCB_FLG_C_BIT] <= c_new;
        if (dec.wdc)
        begin
          wdt_q <= '0;
          flags_q[ccb_pkg::CCB_FLG_TO_BIT] <= 1'b1;
          flags_q[ccb_pkg::CCB_FLG_PD_BIT] <= 1'b1;
        end
      end
    end
  end

  // File registers have no reset, as real data memory
  always_ff @(posedge clk_i)
  begin
    if (mw.we)
      mem_q[mw.addr] <= mw.data;
    else if (bus_wr && adr_i == ccb_pkg::CCB_OFS_RDATA)
      mem_q[raddr_q] <= dat_i[7:0];
  end

  // ----------------------------------------
  // Bus answer: one wait state, unmapped reads zero
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    case (adr_i)
      ccb_pkg::CCB_OFS_INSTR: rd_mux = {16'h0000, instr_q};
      ccb_pkg::CCB_OFS_CTRL:  rd_mux = {30'h0, ctrl_q};
      ccb_pkg::CCB_OFS_ACC:   rd_mux = {24'h0, acc_q};
      ccb_pkg::CCB_OFS_FLAGS: rd_mux = {24'h0, flags_q};
      ccb_pkg::CCB_OFS_BSR:   rd_mux = {28'h0, bsr_q};
      ccb_pkg::CCB_OFS_STAT:  rd_mux = {29'h0, skip_q, (state_q != CCB_ST_IDLE), 1'b0};
      ccb_pkg::CCB_OFS_WDT:   rd_mux = {{(32-WDT_W){1'b0}}, wdt_q};
      ccb_pkg::CCB_OFS_FSR:   rd_mux = {20'h0, fsr_q};
      ccb_pkg::CCB_OFS_RADDR: rd_mux = {20'h0, raddr_q};
      ccb_pkg::CCB_OFS_RDATA: rd_mux = {24'h0, mem_q[raddr_q]};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req;
      dat_q <= rd_mux;
    end
  end

  assign ack_o  = ack_q;
  assign dat_o  = dat_q;
  assign skip_o = skip_q;

  // Busy is registered from the next state, so it matches the state register
  logic busy_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_q <= 1'b0;
    else
      busy_q <= (state_d != CCB_ST_IDLE);
  end
  assign busy_o = busy_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_skip_one;
    skip_q ##1 !skip_q;
  endsequence

  AST_CLR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.clr |=> flags_q[ccb_pkg::CCB_FLG_Z_BIT] && mem_q[$past(eff_addr)] == 8'h00)
    else $error("clear did not zero target");
  AST_BANK_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.acc |-> eff_addr == {bsr_q, dec.fadr})
    else $error("bank select addressing wrong");
  AST_IDX_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && use_idx |-> eff_addr == fsr_q + {4'h0, dec.fadr})
    else $error("indexed addressing wrong");
  AST_WDT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.wdc |=> wdt_q == '0)
    else $error("watchdog not cleared");
  AST_WDT_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.wdc |=> flags_q[ccb_pkg::CCB_FLG_TO_BIT] && flags_q[ccb_pkg::CCB_FLG_PD_BIT])
    else $error("watchdog flags not set");
  AST_INV_ACC: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.inv && !dec.dst |=> acc_q == ~$past(fval))
    else $error("invert to accumulator wrong");
  AST_CMP_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.cmp != ccb_pkg::CCB_CMP_NONE |=> $stable(flags_q))
    else $error("compare changed flags");
  AST_SKIP_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cmp_hit && !ctrl_q[ccb_pkg::CCB_CTRL_TWOW_BIT] |=> s_skip_one)
    else $error("single skip length wrong");
  AST_SKIP_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cmp_hit && ctrl_q[ccb_pkg::CCB_CTRL_TWOW_BIT] |=> skip_q[*2] ##1 !skip_q)
    else $error("double skip length wrong");

endmodule

/* File: src/ccb_pkg.sv */
// Purpose: Shared constants and carriers for the clear/compare/BCD execution unit
// Assumes: 8-bit datapath, 16-bit instruction words, 100 MHz core clock
// Notes:   Offsets are byte addresses on a classic Wishbone slave
package ccb_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] CCB_OFS_INSTR  = 6'h00;
  localparam logic [5:0] CCB_OFS_CTRL   = 6'h04;
  localparam logic [5:0] CCB_OFS_ACC    = 6'h08;
  localparam logic [5:0] CCB_OFS_FLAGS  = 6'h0C;
  localparam logic [5:0] CCB_OFS_BSR    = 6'h10;
  localparam logic [5:0] CCB_OFS_STAT   = 6'h14;
  localparam logic [5:0] CCB_OFS_WDT    = 6'h18;
  localparam logic [5:0] CCB_OFS_FSR    = 6'h1C;
  localparam logic [5:0] CCB_OFS_RADDR  = 6'h20;
  localparam logic [5:0] CCB_OFS_RDATA  = 6'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CCB_CTRL_EXT_BIT   = 0;
  localparam int CCB_CTRL_TWOW_BIT  = 1;
  localparam int CCB_FLG_C_BIT      = 0;
  localparam int CCB_FLG_DC_BIT     = 1;
  localparam int CCB_FLG_Z_BIT      = 2;
  localparam int CCB_FLG_OV_BIT     = 3;
  localparam int CCB_FLG_N_BIT      = 4;
  localparam int CCB_FLG_PD_BIT     = 5;
  localparam int CCB_FLG_TO_BIT     = 6;

  // ----------------------------------------
  // Reset values and opcodes
  // ----------------------------------------
  localparam logic [7:0]  CCB_RST_FLAGS   = 8'h60;
  localparam logic [7:0]  CCB_RST_BYTE    = 8'h00;
  localparam logic [7:0]  CCB_ACC_LIMIT   = 8'h5F;
  localparam logic [3:0]  CCB_BCD_MAX     = 4'h9;
  localparam logic [3:0]  CCB_BCD_FIX     = 4'h6;
  localparam logic [6:0]  CCB_OPC_CLR     = 7'h35;
  localparam logic [5:0]  CCB_OPC_INV     = 6'h07;
  localparam logic [6:0]  CCB_OPC_SEQ     = 7'h31;
  localparam logic [6:0]  CCB_OPC_SGT     = 7'h32;
  localparam logic [6:0]  CCB_OPC_SLT     = 7'h30;
  localparam logic [15:0] CCB_OPC_WDC     = 16'h0004;
  localparam logic [15:0] CCB_OPC_DAJ     = 16'h0007;

  // ----------------------------------------
  // Decode result and data-memory write
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    CCB_CMP_NONE = 3'h0,
    CCB_CMP_EQ   = 3'h1,
    CCB_CMP_GT   = 3'h2,
    CCB_CMP_LT   = 3'h4
  } ccb_cmp_t;

  typedef struct packed
  {
    logic     clr;
    logic     inv;
    logic     wdc;
    logic     daj;
    ccb_cmp_t cmp;
    logic     dst;
    logic     acc;
    logic [7:0] fadr;
  } ccb_dec_t;

  typedef struct packed
  {
    logic       we;
    logic [11:0] addr;
    logic [7:0] data;
  } ccb_mem_t;

endpackage

/* File: src/ccb_alu.sv */
// Purpose: Combinational result path for the clear/compare/BCD execution unit
// Assumes: Operands already fetched; decode supplied by the caller
// Notes:   Pure logic, no state
`timescale 1ns/1ps

module ccb_alu
(
  // Operands
  input  wire ccb_pkg::ccb_dec_t dec_i,
  input  wire logic [7:0]        fval_i,
  input  wire logic [7:0]        acc_i,
  input  wire logic              c_i,
  input  wire logic              dc_i,
  // Results
  output logic [7:0]             res_o,
  output logic                   skip_o,
  output logic                   c_o
);

  // ----------------------------------------
  // Compare and adjust terms
  // ----------------------------------------
  // Unsigned difference; borrow out means register below accumulator
  wire logic [8:0] diff      = {1'b0, fval_i} - {1'b0, acc_i};
  wire logic       f_eq      = (diff[7:0] == 8'h00);
  wire logic       f_lt      = diff[8];
  wire logic       fix_lo    = (acc_i[3:0] > ccb_pkg::CCB_BCD_MAX) || dc_i;
  wire logic [4:0] lo_sum    = {1'b0, acc_i[3:0]} + (fix_lo ? {1'b0, ccb_pkg::CCB_BCD_FIX} : 5'h00);
  wire logic [3:0] hi_in     = acc_i[7:4] + {3'h0, lo_sum[4]};
  // High digit is judged after the low carry too, so 9A still gives valid BCD
  wire logic       fix_hi    = (acc_i[7:4] > ccb_pkg::CCB_BCD_MAX) || (hi_in > ccb_pkg::CCB_BCD_MAX) || c_i;
  wire logic [4:0] hi_sum    = {1'b0, hi_in} + (fix_hi ? {1'b0, ccb_pkg::CCB_BCD_FIX} : 5'h00);
  wire logic       hi_wrap   = (acc_i[7:4] == 4'hF) && lo_sum[4];

  // Compare selection, flags never touched here
  assign skip_o = ((dec_i.cmp == ccb_pkg::CCB_CMP_EQ) && f_eq) ||
                  ((dec_i.cmp == ccb_pkg::CCB_CMP_GT) && !f_lt && !f_eq) ||
                  ((dec_i.cmp == ccb_pkg::CCB_CMP_LT) && f_lt);

  // Result byte selection
  assign res_o = dec_i.clr ? ccb_pkg::CCB_RST_BYTE :
                 dec_i.inv ? ~fval_i :
                 dec_i.daj ? {hi_sum[3:0], lo_sum[3:0]} :
                 acc_i;

  // Carry: set on high correction overflow or on high digit wrap from the low carry, else kept
  assign c_o = (fix_hi && hi_sum[4]) || hi_wrap || c_i;

endmodule

/* File: testbench/clear_compare_bcd_ops_tb.sv */
// Purpose: Self-checking bench for the clear/compare/BCD execution unit
// Assumes: Wishbone answer one cycle after the taking edge; flags register is writable
// Notes:   Skip slots are counted on skip_o while the unit stays busy
`timescale 1ns/1ps

module clear_compare_bcd_ops_tb;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [5:0]  adr_i = 6'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        busy_o;
  logic        skip_o;
  int          err_total = 0;
  int          comparisons = 0;
  int          skip_cnt = 0;

  ccb_core dut
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .adr_i  (adr_i),
    .sel_i  (sel_i),
    .dat_i  (dat_i),
    .dat_o  (dat_o),
    .ack_o  (ack_o),
    .busy_o (busy_o),
    .skip_o (skip_o)
  );

  // Clock and discarded-slot counter
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (skip_o === 1'b1)
      skip_cnt++;

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 40);
    if (n >= 40)
      chk(32'h0, 32'h1, "no ack");
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp, m);
  endtask

  task automatic setm(input logic [11:0] ad, input logic [7:0] v);
    wr(ccb_pkg::CCB_OFS_RADDR, {20'h0, ad});
    wr(ccb_pkg::CCB_OFS_RDATA, {24'h0, v});
  endtask

  task automatic getm(input logic [11:0] ad, input logic [7:0] v, input string m);
    wr(ccb_pkg::CCB_OFS_RADDR, {20'h0, ad});
    rd(ccb_pkg::CCB_OFS_RDATA, {24'h0, v}, m);
  endtask

  // Issue one instruction, wait for busy to fall, count no-op slots
  task automatic exec(input logic [15:0] ins, input int nskip, input string m);
    int n;
    skip_cnt = 0;
    wr(ccb_pkg::CCB_OFS_INSTR, {16'h0, ins});
    repeat (2) @(posedge clk_i);
    n = 0;
    while (busy_o !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(skip_cnt), 32'(nskip), m);
    chk({31'h0, busy_o}, 32'h0, "busy stuck");
    rd(ccb_pkg::CCB_OFS_STAT, 32'h0, "status not idle");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_clear();
    setm(12'h005, 8'h5A);
    wr(ccb_pkg::CCB_OFS_FLAGS, 32'h0);
    exec(16'h6A05, 0, "clr skip");
    getm(12'h005, 8'h00, "clr data");
    rd(ccb_pkg::CCB_OFS_FLAGS, 32'h04, "clr zero");
    setm(12'h305, 8'h77);
    wr(ccb_pkg::CCB_OFS_BSR, 32'h3);
    exec(16'h6B05, 0, "clr banked");
    getm(12'h305, 8'h00, "clr bank");
    setm(12'h105, 8'h11);
    setm(12'h005, 8'h22);
    setm(12'h060, 8'h33);
    wr(ccb_pkg::CCB_OFS_CTRL, 32'h1);
    wr(ccb_pkg::CCB_OFS_FSR, 32'h100);
    exec(16'h6A05, 0, "clr indexed");
    getm(12'h105, 8'h00, "indexed target");
    getm(12'h005, 8'h22, "access untouched");
    exec(16'h6A60, 0, "clr above limit");
    getm(12'h060, 8'h00, "above limit bank");
    wr(ccb_pkg::CCB_OFS_CTRL, 32'h0);
  endtask

  task automatic t_invert();
    wr(ccb_pkg::CCB_OFS_FLAGS, 32'h0);
    wr(ccb_pkg::CCB_OFS_ACC, 32'h0);
    setm(12'h010, 8'h13);
    exec(16'h1C10, 0, "inv to acc");
    rd(ccb_pkg::CCB_OFS_ACC, 32'hEC, "inv acc");
    getm(12'h010, 8'h13, "inv src kept");
    rd(ccb_pkg::CCB_OFS_FLAGS, 32'h10, "inv neg");
    exec(16'h1E10, 0, "inv to reg");
    getm(12'h010, 8'hEC, "inv reg");
    setm(12'h011, 8'hFF);
    exec(16'h1E11, 0, "inv ff");
    getm(12'h011, 8'h00, "inv zero data");
    rd(ccb_pkg::CCB_OFS_FLAGS, 32'h04, "inv zero");
  endtask

  task automatic t_compare();
    logic [6:0] ops [3];
    logic [7:0] rv [3];
    logic [7:0] av [3];
    int hit;
    ops = '{ccb_pkg::CCB_OPC_SEQ, ccb_pkg::CCB_OPC_SGT, ccb_pkg::CCB_OPC_SLT};
    rv  = '{8'h90, 8'h80, 8'h10};
    av  = '{8'h80, 8'h80, 8'hF0};
    for (int tw = 0; tw < 2; tw++)
      for (int i = 0; i < 3; i++)
        for (int j = 0; j < 3; j++)
        begin
          wr(ccb_pkg::CCB_OFS_CTRL, 32'(tw << 1));
          setm(12'h020, rv[j]);
          wr(ccb_pkg::CCB_OFS_ACC, {24'h0, av[j]});
          wr(ccb_pkg::CCB_OFS_FLAGS, 32'h1F);
          hit = (i == 0) ? int'(rv[j] == av[j]) : (i == 1) ? int'(rv[j] > av[j]) : int'(rv[j] < av[j]);
          exec({ops[i], 1'b0, 8'h20}, hit * (tw + 1), "cmp skip");
          rd(ccb_pkg::CCB_OFS_FLAGS, 32'h1F, "cmp flags");
        end
    wr(ccb_pkg::CCB_OFS_CTRL, 32'h0);
  endtask

  task automatic t_watchdog();
    logic [31:0] q;
    wr(ccb_pkg::CCB_OFS_FLAGS, 32'h0);
    repeat (300) @(posedge clk_i);
    exec(ccb_pkg::CCB_OPC_WDC, 0, "wdc skip");
    rd(ccb_pkg::CCB_OFS_FLAGS, 32'h60, "wdc flags");
    wb(1'b0, ccb_pkg::CCB_OFS_WDT, 32'h0, q);
    chk({31'h0, q < 32'h20}, 32'h1, "wdc counter");
  endtask

  task automatic t_decimal();
    logic [7:0] ain [5];
    logic [7:0] aout [5];
    logic [1:0] fin [5];
    logic       cout [5];
    ain  = '{8'hA5, 8'h0F, 8'h42, 8'h9A, 8'h23};
    fin  = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b00};
    aout = '{8'h05, 8'h15, 8'h48, 8'h00, 8'h23};
    cout = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      wr(ccb_pkg::CCB_OFS_ACC, {24'h0, ain[i]});
      wr(ccb_pkg::CCB_OFS_FLAGS, {28'h0, 2'b01, fin[i]});
      exec(ccb_pkg::CCB_OPC_DAJ, 0, "daj skip");
      rd(ccb_pkg::CCB_OFS_ACC, {24'h0, aout[i]}, "daj acc");
      rd(ccb_pkg::CCB_OFS_FLAGS, {28'h0, 2'b01, fin[i][1], cout[i]}, "daj flags");
    end
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ccb_pkg::CCB_OFS_FLAGS, {24'h0, ccb_pkg::CCB_RST_FLAGS}, "reset flags");
    rd(6'h3C, 32'h0, "unmapped read");
    t_clear();
    t_invert();
    t_compare();
    t_watchdog();
    t_decimal();
    wrap_up();
  end

  // Watchdog sized well above the roughly one thousand cycles the scenarios need
  initial
  begin
    #400000;
    err_total++;
    $display("BAD %0t timeout", $time);
    wrap_up();
  end

endmodule
